// ===== hw/sink_ctrl_regs.svh
// Named constants for the serial sink driver control logic.
// Assumes inclusion by bare name from the design files of this block.
`ifndef SINK_CTRL_REGS_SVH
`define SINK_CTRL_REGS_SVH

// Channel count and word width of shift register and latches
`define SINK_WIDTH        8
`define SINK_MSB          7
`define SINK_ZERO         8'h00
// Global gain: 256 steps, code 8'hff is the full-gain end of the range
`define GAIN_STEPS        256
`define GAIN_RESET        8'hff
// Sampled enable history low, high, low marks a one-period pulse
`define OE_PULSE_PATTERN  3'h2
// Pad defaults when the controller leaves a pin undriven
`define STROBE_IDLE       1'h0
`define ENABLE_N_IDLE     1'h1
// Error buffer geometry
`define ERRBUF_DEPTH      2

`endif

// ===== hw/sink_ctrl_pkg.sv
// Types shared by the sink driver control logic.
// Assumes the constants header is compiled alongside.
package sink_ctrl_pkg;

    // Control phases: normal, mode switching, special
    typedef enum logic [1:0] {
        PH_NORMAL,
        PH_SWITCH,
        PH_SPECIAL
    } phase_type;

    // One bit per output channel
    typedef logic [7:0] chan_type;

endpackage : sink_ctrl_pkg

// ===== hw/edge_detect.sv
// Rising and falling edge detector for one synchronous input.
// Assumes the input is already synchronous to clk.
`timescale 1ns/1ps
`include "sink_ctrl_regs.svh"

module edge_detect #(
    parameter logic RESET_LEVEL = 1'h0
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic sig,
    output logic      rise,
    output logic      fall
);

    logic prev_r;

    ////////////////////////////////////////////////////////////////////////
    // Previous level; reset value is the pad's idle level
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev_r <= RESET_LEVEL;
        end else begin
            prev_r <= sig;
        end
    end

    // Edges are combinational so the caller acts in the edge cycle
    assign rise = sig & ~prev_r;
    assign fall = ~sig & prev_r;

endmodule : edge_detect

// ===== hw/two_entry_buffer.sv
// Small valid/ready buffer holding error snapshots.
// Assumes the drain side may stall for any number of cycles.
`timescale 1ns/1ps
`include "sink_ctrl_regs.svh"

module two_entry_buffer #(
    parameter int WIDTH = `SINK_WIDTH,
    parameter int DEPTH = `ERRBUF_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr_r;
    logic [PW-1:0]    rdPtr_r;
    logic [PW:0]      count_r;
    logic             push;
    logic             pop;

    // Honest full and empty from the occupancy count
    assign inReady  = (count_r != (PW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;
    assign outData  = mem[rdPtr_r];

    ////////////////////////////////////////////////////////////////////////
    // Pointers wrap on the depth, which need not be a power of two
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= (wrPtr_r == PW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= (rdPtr_r == PW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
            end
            count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // Storage needs no reset; valid is carried by the count
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

endmodule : two_entry_buffer

// ===== hw/serial_led_sink_driver_ctrl.sv
// Control logic of an eight-channel serial sink driver.
// Assumes serial clock, strobe and enable are synchronous to clk and that
// the pads resolve undriven strobe low and undriven enable high.
`timescale 1ns/1ps
`include "sink_ctrl_regs.svh"

module serial_led_sink_driver_ctrl (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic                   serialClk,
    input  wire logic                   serialIn,
    input  wire logic                   latchStrobe,
    input  wire logic                   outputEnableN,
    input  wire sink_ctrl_pkg::chan_type channelFault,
    output logic                        serialOut,
    output sink_ctrl_pkg::chan_type     sinkChannels,
    output sink_ctrl_pkg::chan_type     gainCode,
    output logic                        specialMode
);
    import sink_ctrl_pkg::*;

    phase_type phase_r;
    phase_type phaseNxt;
    chan_type  shiftReg_r;
    chan_type  shiftRegNxt;
    chan_type  outLatch_r;
    chan_type  outLatchNxt;
    chan_type  configLatch_r;
    chan_type  errorSticky_r;
    chan_type  errorStickyNxt;
    chan_type  errSample;
    chan_type  bufOutData;
    chan_type  sinkOn_r;
    logic      specialMode_r;
    logic [1:0] oeHist_r;
    logic      sclkRise;
    logic      strobeRise;
    logic      oeFall;
    logic      oePulse;
    logic      inSpecial;
    logic      inNormal;
    logic      selectDone;
    logic      errClear;
    logic      capReq_r;
    logic      bufInReady;
    logic      bufOutValid;
    logic      bufOutReady;
    logic      loadErr;
    logic      transparent;
    logic      configWrite;

    ////////////////////////////////////////////////////////////////////////
    // Edge detectors; history resets to pad idle levels
    edge_detect #(.RESET_LEVEL(1'h0)) sclkEdge (
        .clk     (clk),
        .sys_rst (sys_rst),
        .sig     (serialClk),
        .rise    (sclkRise),
        .fall    ()
    );

    edge_detect #(.RESET_LEVEL(`STROBE_IDLE)) strobeEdge (
        .clk     (clk),
        .sys_rst (sys_rst),
        .sig     (latchStrobe),
        .rise    (strobeRise),
        .fall    ()
    );

    edge_detect #(.RESET_LEVEL(`ENABLE_N_IDLE)) enableEdge (
        .clk     (clk),
        .sys_rst (sys_rst),
        .sig     (outputEnableN),
        .rise    (),
        .fall    (oeFall)
    );

    ////////////////////////////////////////////////////////////////////////
    // Mode detection: enable seen high at exactly one serial rise
    assign oePulse    = sclkRise &
                        ({oeHist_r, outputEnableN} == `OE_PULSE_PATTERN);
    assign inSpecial  = (phase_r == PH_SPECIAL);
    assign inNormal   = (phase_r == PH_NORMAL);
    assign selectDone = (phase_r == PH_SWITCH) & sclkRise;
    // Clear only on a real return from special to normal
    assign errClear   = selectDone & ~latchStrobe & specialMode_r;

    // Phase sequencing; switching lasts until the next serial rise
    always_comb begin
        phaseNxt = phase_r;
        case (phase_r)
            PH_NORMAL: begin
                if (oePulse) begin
                    phaseNxt = PH_SWITCH;
                end
            end
            PH_SWITCH: begin
                if (sclkRise) begin
                    phaseNxt = latchStrobe ? PH_SPECIAL : PH_NORMAL;
                end
            end
            PH_SPECIAL: begin
                if (oePulse) begin
                    phaseNxt = PH_SWITCH;
                end
            end
            default: begin
                phaseNxt = PH_NORMAL;
            end
        endcase
    end

    // Phase, mode and enable history
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase_r       <= PH_NORMAL;
            specialMode_r <= 1'h0;
            oeHist_r      <= {2{`ENABLE_N_IDLE}};
        end else begin
            phase_r <= phaseNxt;
            if (selectDone) begin
                specialMode_r <= latchStrobe;
            end
            if (sclkRise) begin
                oeHist_r <= {oeHist_r[0], outputEnableN};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error status: sampled while enabled in special mode, sticky per
    // channel, and a new fault wins over a clear in the same cycle
    assign errSample = (inSpecial & ~outputEnableN) ? channelFault
                                                    : `SINK_ZERO;
    assign errorStickyNxt = (errClear ? `SINK_ZERO : errorSticky_r)
                            | errSample;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            errorSticky_r <= `SINK_ZERO;
        end else begin
            errorSticky_r <= errorStickyNxt;
        end
    end

    // Snapshot request on each enable fall in special mode; held while the
    // buffer is full, so a slow reader delays capture instead of losing it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            capReq_r <= 1'h0;
        end else if (oeFall & inSpecial) begin
            capReq_r <= 1'h1;
        end else if (bufInReady) begin
            capReq_r <= 1'h0;
        end
    end

    two_entry_buffer #(.WIDTH(`SINK_WIDTH), .DEPTH(`ERRBUF_DEPTH)) errBuf (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .inValid  (capReq_r),
        .inReady  (bufInReady),
        .inData   (errorSticky_r),
        .outValid (bufOutValid),
        .outReady (bufOutReady),
        .outData  (bufOutData)
    );

    ////////////////////////////////////////////////////////////////////////
    // Shift register: a waiting snapshot replaces the shift on one rise,
    // trading that input bit for a parallel status load
    assign bufOutReady = sclkRise & inSpecial;
    assign loadErr     = bufOutReady & bufOutValid;
    assign shiftRegNxt = loadErr  ? bufOutData :
                         sclkRise ? {shiftReg_r[`SINK_MSB-1:0], serialIn}
                                  : shiftReg_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shiftReg_r <= `SINK_ZERO;
        end else begin
            shiftReg_r <= shiftRegNxt;
        end
    end

    // Last stage is the chain output to the next driver
    assign serialOut = shiftReg_r[`SINK_MSB];

    ////////////////////////////////////////////////////////////////////////
    // Latches: output latch transparent only in normal phase; special-mode
    // strobe pulses go to the configuration latch instead
    assign transparent = inNormal & latchStrobe;
    assign configWrite = inSpecial & strobeRise;
    assign outLatchNxt = transparent ? shiftReg_r : outLatch_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            outLatch_r    <= `SINK_ZERO;
            configLatch_r <= `GAIN_RESET;
        end else begin
            outLatch_r <= outLatchNxt;
            if (configWrite) begin
                configLatch_r <= shiftReg_r;
            end
        end
    end

    // Global gain code for the current regulator, one of 256 steps
    assign gainCode = configLatch_r;

    ////////////////////////////////////////////////////////////////////////
    // Channel drive: same enable gating in every mode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sinkOn_r <= `SINK_ZERO;
        end else begin
            sinkOn_r <= outLatchNxt & {`SINK_WIDTH{~outputEnableN}};
        end
    end

    assign sinkChannels = sinkOn_r;
    assign specialMode  = specialMode_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the logic above
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_SHIFT: assert property (sclkRise && !loadErr |=>
        shiftReg_r == {$past(shiftReg_r[`SINK_MSB-1:0]), $past(serialIn)})
        else $error("shift register did not advance");

    AST_SEROUT: assert property (sclkRise && !loadErr |=>
        serialOut == $past(shiftReg_r[`SINK_MSB-1]))
        else $error("serial output not from last stage");

    AST_TRANSP: assert property (inNormal && latchStrobe |=>
        outLatch_r == $past(shiftReg_r))
        else $error("latch not transparent");

    AST_HOLD: assert property (!latchStrobe |=> $stable(outLatch_r))
        else $error("latch changed while strobe low");

    AST_BLANK: assert property (outputEnableN |=>
        sinkChannels == `SINK_ZERO)
        else $error("channels not blanked");

    AST_ENABLE: assert property (!outputEnableN |=>
        sinkChannels == $past(outLatchNxt))
        else $error("enabled channels do not follow latch");

    AST_ENTER: assert property (oePulse && phase_r != PH_SWITCH |=>
        phase_r == PH_SWITCH)
        else $error("enable pulse did not start mode switching");

    AST_SELECT: assert property (selectDone |=>
        specialMode == $past(latchStrobe) && phase_r != PH_SWITCH)
        else $error("mode not chosen by strobe level");

    AST_CONFIG: assert property (configWrite |=>
        gainCode == $past(shiftReg_r) && $stable(outLatch_r))
        else $error("configuration latch write wrong");

    AST_CLEAR: assert property (errClear |=>
        errorSticky_r == $past(errSample))
        else $error("error status not cleared on return");

    AST_STICKY: assert property (1'b1 |=>
        (errorSticky_r & $past(errSample)) == $past(errSample))
        else $error("sampled fault lost");

    AST_LOAD: assert property (loadErr |=>
        shiftReg_r == $past(bufOutData))
        else $error("error status not loaded");

    AST_RESET: assert property (@(posedge clk) disable iff (1'b0)
        sys_rst |=> gainCode == `GAIN_RESET && !specialMode
        && phase_r == PH_NORMAL)
        else $error("wrong state after reset");

    COV_SPECIAL: cover property (selectDone && latchStrobe);
    COV_CONFIG: cover property (configWrite);
    COV_ERRLOAD: cover property (loadErr ##[1:8] sclkRise);
    COV_FULL: cover property (capReq_r && !bufInReady);
    COV_RETURN: cover property (errClear);

endmodule : serial_led_sink_driver_ctrl

// ===== sim/serial_ctrl_model.sv
// Controller model that drives the serial, strobe and enable pins.
// Assumes the bench calls its tasks one at a time, never concurrently.
`timescale 1ns/1ps

module serial_ctrl_model (
    input  wire logic clk,
    output logic      serialClk,
    output logic      serialIn,
    output logic      latchStrobe,
    output logic      outputEnableN
);

    // Undriven pad levels until the controller takes over
    initial begin
        serialClk     = 1'h0;
        serialIn      = 1'h0;
        latchStrobe   = 1'h0;
        outputEnableN = 1'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // One serial clock: high one cycle, low one cycle; data inverted after
    // so a stale bit is never mistaken for a held one
    task automatic rise(input logic d);
        @(posedge clk);
        serialIn  <= d;
        serialClk <= 1'h1;
        @(posedge clk);
        serialClk <= 1'h0;
        serialIn  <= ~d;
        @(posedge clk);
    endtask : rise

    // Eight bits, first bit ends up at the far stage
    task automatic send_word(input logic [7:0] w);
        for (int i = 7; i >= 0; i--) begin
            rise(w[i]);
        end
    endtask : send_word

    // Strobe high for one clock cycle
    task automatic strobe_pulse();
        @(posedge clk);
        latchStrobe <= 1'h1;
        @(posedge clk);
        latchStrobe <= 1'h0;
    endtask : strobe_pulse

    // Enable level change at a clock edge, no serial activity
    task automatic enable(input logic v);
        @(posedge clk);
        outputEnableN <= v;
    endtask : enable

    // Enable high across nHigh serial rises, then strobe picks the mode;
    // nHigh other than one is a malformed request
    task automatic switch_mode(input int nHigh, input logic sel);
        enable(1'h0);
        rise(1'h0);
        outputEnableN <= 1'h1;
        repeat (nHigh) rise(1'h0);
        outputEnableN <= 1'h0;
        rise(1'h0);
        latchStrobe <= sel;
        rise(1'h0);
        latchStrobe <= 1'h0;
    endtask : switch_mode

endmodule : serial_ctrl_model

// ===== sim/serial_led_sink_driver_ctrl_tb.sv
// Self-checking bench for the serial sink driver control logic.
// Assumes the controller model file and the design files are compiled first.
`timescale 1ns/1ps

`define CHECK(got, exp) begin testsRun++; if ((got) !== (exp)) begin \
    nErrors++; $display("unexpected at %0t got %h exp %h", \
    $time, (got), (exp)); end end

module serial_led_sink_driver_ctrl_tb;
    import sink_ctrl_pkg::*;

    logic     clk = 1'h0;
    logic     sys_rst;
    logic     serialClk;
    logic     serialIn;
    logic     latchStrobe;
    logic     outputEnableN;
    chan_type channelFault;
    logic     serialOut;
    chan_type sinkChannels;
    chan_type gainCode;
    logic     specialMode;
    int       seed = 27705;
    int       nErrors = 0;
    int       testsRun = 0;
    chan_type w;
    chan_type nxt;
    chan_type lat;
    chan_type g;
    chan_type f;

    ////////////////////////////////////////////////////////////////////////
    // 20 MHz clock
    always #25 clk = ~clk;

    serial_ctrl_model ctl (
        .clk          (clk),
        .serialClk    (serialClk),
        .serialIn     (serialIn),
        .latchStrobe  (latchStrobe),
        .outputEnableN(outputEnableN)
    );

    serial_led_sink_driver_ctrl dut (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .serialClk    (serialClk),
        .serialIn     (serialIn),
        .latchStrobe  (latchStrobe),
        .outputEnableN(outputEnableN),
        .channelFault (channelFault),
        .serialOut    (serialOut),
        .sinkChannels (sinkChannels),
        .gainCode     (gainCode),
        .specialMode  (specialMode)
    );

    ////////////////////////////////////////////////////////////////////////
    // Channels follow the latch only while the enable is low
    function automatic chan_type sinkExpect(chan_type l, logic oeN);
        return oeN ? 8'h00 : l;
    endfunction : sinkExpect

    // Sample away from the driving edge so no update races the check
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    // First rise loads the snapshot, eight more walk it out top bit first
    task automatic read_status(input chan_type e);
        ctl.rise(1'h0);
        for (int i = 7; i >= 0; i--) begin
            settle(0);
            `CHECK(serialOut, e[i])
            ctl.rise(1'h0);
        end
    endtask : read_status

    // Enable high for a cycle: the falling edge asks for a snapshot
    task automatic snap(input chan_type fault);
        @(posedge clk) channelFault <= fault;
        settle(2);
        ctl.enable(1'h1);
        ctl.enable(1'h0);
        settle(4);
    endtask : snap

    task automatic wrapUp();
        if (nErrors == 0 && testsRun > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrapUp

    // Hang guard at 20000 cycles, well above the few hundred cycles the run needs
    initial begin
        #(20000 * 50);
        nErrors++;
        wrapUp();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        sys_rst      <= 1'h1;
        channelFault <= 8'h00;
        repeat (10) @(posedge clk);
        sys_rst <= 1'h0;
        settle(1);
        `CHECK({serialOut, specialMode}, 2'h0)
        `CHECK(gainCode, 8'hff)
        `CHECK(sinkChannels, 8'h00)
        // A two-rise enable pulse is not a mode request
        ctl.switch_mode(2, 1'h1);
        settle(2);
        `CHECK(specialMode, 1'h0)
        // Chained shifting, latching, holding and blanking
        // Faults outside special mode must never reach the status bits
        for (int k = 0; k < 4; k++) begin
            @(posedge clk) channelFault <= 8'($random(seed));
            w = 8'($random(seed));
            nxt = 8'($random(seed));
            ctl.send_word(w);
            for (int i = 7; i >= 0; i--) begin
                settle(0);
                `CHECK(serialOut, w[i])
                ctl.rise(nxt[i]);
            end
            ctl.strobe_pulse();
            settle(2);
            `CHECK(sinkChannels, sinkExpect(nxt, 1'h0))
            ctl.send_word(~nxt);
            settle(2);
            `CHECK(sinkChannels, sinkExpect(nxt, 1'h0))
            ctl.enable(1'h1);
            settle(2);
            `CHECK(sinkChannels, sinkExpect(nxt, 1'h1))
            ctl.enable(1'h0);
            settle(2);
            `CHECK(sinkChannels, sinkExpect(nxt, 1'h0))
            lat = nxt;
        end
        // Special mode: configuration writes leave the output latch alone
        @(posedge clk) channelFault <= 8'h00;
        ctl.switch_mode(1, 1'h1);
        settle(2);
        `CHECK(specialMode, 1'h1)
        for (int k = 0; k < 3; k++) begin
            g = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
            ctl.send_word(g);
            ctl.strobe_pulse();
            settle(2);
            `CHECK(gainCode, g)
            `CHECK(sinkChannels, sinkExpect(lat, 1'h0))
        end
        // Two snapshots wait while the reader stalls; faults are sticky
        f = 8'($random(seed)) | 8'h81;
        w = 8'($random(seed));
        snap(f);
        snap(w);
        @(posedge clk) channelFault <= 8'h00;
        ctl.rise(1'h0);
        settle(0);
        `CHECK(serialOut, f[7])
        read_status(f | w);
        // Back to normal clears the sticky status
        ctl.switch_mode(1, 1'h0);
        settle(2);
        `CHECK(specialMode, 1'h0)
        ctl.switch_mode(1, 1'h1);
        ctl.rise(1'h0);
        snap(8'h00);
        read_status(8'h00);
        // Reset in the middle of special mode returns to the start state
        @(posedge clk) sys_rst <= 1'h1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        settle(1);
        `CHECK({specialMode, sinkChannels}, 9'h000)
        `CHECK(gainCode, 8'hff)
        wrapUp();
    end

endmodule : serial_led_sink_driver_ctrl_tb
